// ---- hdl/lcdcg_dev.sv ----
// How it works
// - Code bits 3..0 give pattern address 6..3
// - Pattern address bits 2..0 pick cell line
// - Eighth line ORs stored pattern with cursor
// - Data bits 4..0 drive columns, bit4 leftmost
// - Code upper nibble zero selects user pattern
// - One bit lights pixel, zero leaves off
// - Set-pattern-address loads counter bits 5..0 only
// - Bit 6 changes via text-address, clear, home, cursor shift or counter step
// - Busy read returns all seven counter bits
// - Host sets N,M 0,0 for 1:16
// - Host sets M,N 0,1 for 2x24
// - Host sets N,M 1,1 for 4x12
// - Initialization starts by itself after reset
// - Reset clears text, sets default modes
// - Counter points to text RAM after reset
// - Busy reads one until initialization ends
// - Power-on busy lasts two milliseconds
// - Host instruction sequence may also initialize
// - Instructions during busy are not executed
// - Busy on bit 7, counter below
`default_nettype none
module lcdcg_dev
    import lcdcg_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = BUSY_CYC,
    parameter int unsigned EXEC_CYCLES = EXEC_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_ce,
    lcdcg_if.dev            bus,
    input  wire logic [7:0] i_pix_code,
    input  wire logic [2:0] i_pix_line,
    input  wire logic       i_pix_cursor,
    input  wire logic [4:0] i_rom_pixels,
    input  wire logic [6:0] i_scan_addr,
    output logic      [4:0] o_pixels,
    output logic            o_from_user_ram,
    output logic      [7:0] o_scan_char,
    output logic            o_busy_indicator,
    output logic      [6:0] o_addr_counter,
    output logic            o_addr_in_pattern,
    output logic      [6:0] o_disp_offset,
    output logic            o_disp_on,
    output logic            o_cursor_on,
    output logic            o_blink_on,
    output logic            o_incr,
    output logic            o_shift_on_write,
    output logic            o_interface_width_select,
    output logic            o_lines_n,
    output logic            o_lines_m,
    output logic            o_vgen_boost
);
    localparam int unsigned BW = $clog2(BUSY_CYCLES + 1);

    typedef struct packed {
        logic [BW-1:0] busy_cnt;
        logic          clr_active;
        logic [6:0]    clr_addr;
        logic [6:0]    ac;
        logic          sel_pat;
        logic [6:0]    disp_ofs;
        logic          incr;
        logic          shift_en;
        logic          disp;
        logic          cur;
        logic          blink;
        logic          width8;
        logic          lines_n;
        logic          lines_m;
        logic          vgen;
        logic [7:0]    rdata;
        logic          rvalid;
        logic [4:0]    pix;
        logic          from_ram;
        logic [7:0]    scan;
    } lcdcg_dev_t;

    // Power-on: long busy and a text clear run by themselves
    localparam lcdcg_dev_t RST_STATE = '{
        busy_cnt: BW'(BUSY_CYCLES), clr_active: 1'b1,
        incr: RST_INCR, width8: RST_WIDTH8,
        sel_pat: RST_OFF,
        default: '0
    };

    lcdcg_dev_t s_r;
    lcdcg_dev_t s_nxt;

    logic [7:0] text_ram [TEXT_DEPTH];
    logic [4:0] user_pattern_ram [PAT_DEPTH];

    logic       we_txt;
    logic       we_pat;
    logic [6:0] wa;
    logic [7:0] wd;
    logic       busy;
    logic [6:0] pat_addr;
    logic [4:0] row;
    lcdcg_ins_t ins;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt    = s_r;
        we_txt   = 1'b0;
        we_pat   = 1'b0;
        wa       = s_r.ac;
        wd       = bus.wdata;
        busy     = (s_r.busy_cnt != '0);
        ins      = lcdcg_decode(bus.wdata);
        s_nxt.rvalid = 1'b0;
        if (busy) begin
            s_nxt.busy_cnt = BW'(s_r.busy_cnt - 1'b1);
        end
        // Clear walks the whole text RAM while busy
        if (s_r.clr_active) begin
            we_txt = 1'b1;
            wa     = s_r.clr_addr;
            wd     = BLANK_CODE;
            s_nxt.clr_addr = 7'(s_r.clr_addr + 7'h01);
            if (s_r.clr_addr == 7'h7F) begin
                s_nxt.clr_active = 1'b0;
            end
        end
        if (bus.req) begin
            // Every read is answered so the far end never hangs
            s_nxt.rvalid = bus.rw;
            if (bus.rw && !bus.rs) begin
                s_nxt.rdata = {busy, s_r.ac};
            end else if (!busy) begin
                s_nxt.busy_cnt = BW'(EXEC_CYCLES);
                if (bus.rs && bus.rw) begin
                    s_nxt.rdata = s_r.sel_pat ? {3'h0, user_pattern_ram[s_r.ac]}
                                              : text_ram[s_r.ac];
                    s_nxt.ac = lcdcg_step(s_r.ac, s_r.incr);
                end else if (bus.rs) begin
                    we_pat = s_r.sel_pat;
                    we_txt = !s_r.sel_pat;
                    s_nxt.ac = lcdcg_step(s_r.ac, s_r.incr);
                    if (s_r.shift_en && !s_r.sel_pat) begin
                        s_nxt.disp_ofs = lcdcg_step(s_r.disp_ofs, s_r.incr);
                    end
                end else begin
                    case (ins)
                        INS_NOP: begin
                            s_nxt.busy_cnt = '0;
                        end
                        INS_CLR: begin
                            s_nxt.clr_active = 1'b1;
                            s_nxt.clr_addr   = '0;
                            s_nxt.busy_cnt   = BW'(TEXT_DEPTH);
                            s_nxt.ac         = '0;
                            s_nxt.sel_pat    = 1'b0;
                            s_nxt.disp_ofs   = '0;
                        end
                        INS_HOME: begin
                            s_nxt.ac       = '0;
                            s_nxt.sel_pat  = 1'b0;
                            s_nxt.disp_ofs = '0;
                        end
                        INS_ENTRY: begin
                            s_nxt.incr     = bus.wdata[ENT_ID_BIT];
                            s_nxt.shift_en = bus.wdata[ENT_S_BIT];
                        end
                        INS_DCTL: begin
                            s_nxt.disp  = bus.wdata[DCTL_D_BIT];
                            s_nxt.cur   = bus.wdata[DCTL_C_BIT];
                            s_nxt.blink = bus.wdata[DCTL_B_BIT];
                        end
                        INS_SHIFT: begin
                            if (bus.wdata[SHF_SC_BIT]) begin
                                s_nxt.disp_ofs = lcdcg_step(s_r.disp_ofs,
                                                            bus.wdata[SHF_RL_BIT]);
                            end else begin
                                s_nxt.ac = lcdcg_step(s_r.ac, bus.wdata[SHF_RL_BIT]);
                            end
                        end
                        INS_FSET: begin
                            s_nxt.width8  = bus.wdata[FSET_DL_BIT];
                            s_nxt.lines_n = bus.wdata[FSET_N_BIT];
                            s_nxt.lines_m = bus.wdata[FSET_M_BIT];
                            s_nxt.vgen    = bus.wdata[FSET_G_BIT];
                        end
                        INS_SETPAT: begin
                            s_nxt.ac      = {s_r.ac[6], bus.wdata[5:0]};
                            s_nxt.sel_pat = 1'b1;
                        end
                        INS_SETTXT: begin
                            s_nxt.ac      = bus.wdata[6:0];
                            s_nxt.sel_pat = 1'b0;
                        end
                        default: begin
                            s_nxt.busy_cnt = '0;
                        end
                    endcase
                end
            end
        end
        // Pixel path: one register stage
        pat_addr = {i_pix_code[3:0], i_pix_line};
        s_nxt.from_ram = (i_pix_code[7:4] == 4'h0);
        row = s_nxt.from_ram ? user_pattern_ram[pat_addr] : i_rom_pixels;
        if (i_pix_line == CURSOR_LINE) begin
            row = row | {5{i_pix_cursor & s_r.cur}};
        end
        s_nxt.pix  = s_r.disp ? row : 5'h00;
        s_nxt.scan = text_ram[7'(i_scan_addr + s_r.disp_ofs)];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= RST_STATE;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    // Memories carry no reset; the clear sweep initialises text
    always_ff @(posedge i_clk) begin
        if (i_ce && we_txt) begin
            text_ram[wa] <= wd;
        end
        if (i_ce && we_pat) begin
            user_pattern_ram[wa] <= wd[4:0];
        end
    end

    assign bus.rdata                = s_r.rdata;
    assign bus.rvalid               = s_r.rvalid;
    assign o_pixels                 = s_r.pix;
    assign o_from_user_ram          = s_r.from_ram;
    assign o_scan_char              = s_r.scan;
    assign o_busy_indicator         = (s_r.busy_cnt != '0);
    assign o_addr_counter           = s_r.ac;
    assign o_addr_in_pattern        = s_r.sel_pat;
    assign o_disp_offset            = s_r.disp_ofs;
    assign o_disp_on                = s_r.disp;
    assign o_cursor_on              = s_r.cur;
    assign o_blink_on               = s_r.blink;
    assign o_incr                   = s_r.incr;
    assign o_shift_on_write         = s_r.shift_en;
    assign o_interface_width_select = s_r.width8;
    assign o_lines_n                = s_r.lines_n;
    assign o_lines_m                = s_r.lines_m;
    assign o_vgen_boost             = s_r.vgen;
endmodule : lcdcg_dev
`default_nettype wire

// ---- hdl/lcdcg_host.sv ----
`default_nettype none
module lcdcg_host
    import lcdcg_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    lcdcg_if.host            bus,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest
);
    typedef enum logic [2:0] {ST_IDLE, ST_POLL, ST_PWAIT, ST_SEND, ST_RWAIT} lcdcg_st_t;

    typedef struct packed {
        lcdcg_st_t   st;
        logic [9:0]  cmd;
        logic        init_on;
        logic [1:0]  step;
        logic        n;
        logic        m;
        logic        g;
        logic [7:0]  last_rd;
        logic [7:0]  last_stat;
        logic        ack;
        logic [31:0] avs_rd;
        logic        req;
        logic        rs;
        logic        rw;
        logic [7:0]  wdata;
    } lcdcg_host_t;

    lcdcg_host_t s_r;
    lcdcg_host_t s_nxt;
    logic        idle;
    logic        acc;

    // Software init: width, line count, display off, clear, increment
    function automatic logic [7:0] init_cmd(input logic [1:0] k, input logic n,
                                            input logic m, input logic g);
        logic [7:0] c;
        c = INS_FST_CODE;
        case (k)
            2'h0:    c = INS_FST_CODE | (8'h01 << FSET_DL_BIT)
                         | ({7'h00, n} << FSET_N_BIT)
                         | ({7'h00, m} << FSET_M_BIT)
                         | ({7'h00, g} << FSET_G_BIT);
            2'h1:    c = INS_DCT_CODE;
            2'h2:    c = INS_CLR_CODE;
            default: c = INS_ENT_CODE | (8'h01 << ENT_ID_BIT);
        endcase
        return c;
    endfunction : init_cmd

    always_comb begin
        s_nxt     = s_r;
        s_nxt.req = 1'b0;
        s_nxt.ack = 1'b0;
        idle      = (s_r.st == ST_IDLE) && !s_r.init_on;
        acc       = i_avs_read || idle
                    || !((i_avs_address == REG_CMD) || (i_avs_address == REG_INIT));
        // ------------------------------------------------------------
        // Avalon slave
        // ------------------------------------------------------------
        if ((i_avs_read || i_avs_write) && !s_r.ack && acc) begin
            s_nxt.ack = 1'b1;
            if (i_avs_write && i_avs_address == REG_CMD) begin
                s_nxt.cmd = i_avs_writedata[9:0];
                s_nxt.st  = ST_POLL;
            end else if (i_avs_write && i_avs_address == REG_INIT) begin
                s_nxt.n       = i_avs_writedata[INIT_N_BIT];
                s_nxt.m       = i_avs_writedata[INIT_M_BIT];
                s_nxt.g       = i_avs_writedata[INIT_G_BIT];
                s_nxt.init_on = i_avs_writedata[INIT_GO_BIT];
                s_nxt.step    = '0;
            end
            case (i_avs_address)
                REG_STATUS: s_nxt.avs_rd = {16'h0000, s_r.last_stat, 7'h00, !idle};
                REG_RDATA:  s_nxt.avs_rd = {24'h000000, s_r.last_rd};
                REG_INIT:   s_nxt.avs_rd = {28'h0000000, s_r.g, s_r.m, s_r.n,
                                            s_r.init_on};
                default:    s_nxt.avs_rd = 32'h00000000;
            endcase
        end
        // ------------------------------------------------------------
        // Link engine
        // ------------------------------------------------------------
        case (s_r.st)
            ST_IDLE: begin
                if (s_r.init_on) begin
                    s_nxt.cmd = {2'b00, init_cmd(s_r.step, s_r.n, s_r.m, s_r.g)};
                    s_nxt.st  = ST_POLL;
                end
            end
            ST_POLL: begin
                s_nxt.req = 1'b1;
                s_nxt.rs  = 1'b0;
                s_nxt.rw  = 1'b1;
                s_nxt.st  = ST_PWAIT;
            end
            ST_PWAIT: begin
                if (bus.rvalid) begin
                    s_nxt.last_stat = bus.rdata;
                    s_nxt.st = bus.rdata[BUSY_BIT] ? ST_POLL : ST_SEND;
                end
            end
            ST_SEND: begin
                s_nxt.req   = 1'b1;
                s_nxt.rs    = s_r.cmd[CMD_RS_BIT];
                s_nxt.rw    = s_r.cmd[CMD_RW_BIT];
                s_nxt.wdata = s_r.cmd[7:0];
                s_nxt.st    = s_r.cmd[CMD_RW_BIT] ? ST_RWAIT : ST_IDLE;
                if (s_r.init_on) begin
                    s_nxt.step    = 2'(s_r.step + 2'h1);
                    s_nxt.init_on = (s_r.step != 2'(INIT_STEPS - 1));
                end
            end
            ST_RWAIT: begin
                if (bus.rvalid) begin
                    s_nxt.last_rd = bus.rdata;
                    s_nxt.st      = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= '{st: ST_IDLE, default: '0};
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign bus.req           = s_r.req;
    assign bus.rs            = s_r.rs;
    assign bus.rw            = s_r.rw;
    assign bus.wdata         = s_r.wdata;
    assign o_avs_readdata    = s_r.avs_rd;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !s_r.ack;
endmodule : lcdcg_host
`default_nettype wire

// ---- hdl/lcdcg_if.sv ----
`default_nettype none
interface lcdcg_if;
    logic       req;
    logic       rs;
    logic       rw;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;

    modport dev  (input req, rs, rw, wdata, output rdata, rvalid);
    modport host (output req, rs, rw, wdata, input rdata, rvalid);
endinterface : lcdcg_if
`default_nettype wire

// ---- hdl/lcdcg_pkg.sv ----
`default_nettype none
package lcdcg_pkg;
    // ------------------------------------------------------------
    // Timing and memory depths
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned BUSY_TIME_MS = 2;
    localparam int unsigned BUSY_CYC     = BUSY_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned EXEC_CYC     = 3;
    localparam int unsigned TEXT_DEPTH   = 128;
    localparam int unsigned PAT_DEPTH    = 128;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int unsigned ENT_ID_BIT   = 1;
    localparam int unsigned ENT_S_BIT    = 0;
    localparam int unsigned DCTL_D_BIT   = 2;
    localparam int unsigned DCTL_C_BIT   = 1;
    localparam int unsigned DCTL_B_BIT   = 0;
    localparam int unsigned SHF_SC_BIT   = 3;
    localparam int unsigned SHF_RL_BIT   = 2;
    localparam int unsigned FSET_DL_BIT  = 4;
    localparam int unsigned FSET_N_BIT   = 3;
    localparam int unsigned FSET_M_BIT   = 2;
    localparam int unsigned FSET_G_BIT   = 1;
    localparam int unsigned BUSY_BIT     = 7;
    localparam logic [2:0]  CURSOR_LINE  = 3'h7;
    localparam logic [7:0]  BLANK_CODE   = 8'h20;
    localparam logic [7:0]  INS_CLR_CODE = 8'h01;
    localparam logic [7:0]  INS_ENT_CODE = 8'h04;
    localparam logic [7:0]  INS_DCT_CODE = 8'h08;
    localparam logic [7:0]  INS_FST_CODE = 8'h20;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_WIDTH8 = 1'b1;
    localparam logic RST_INCR   = 1'b1;
    localparam logic RST_OFF    = 1'b0;

    // ------------------------------------------------------------
    // Host register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CMD     = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_RDATA   = 4'h8;
    localparam logic [3:0] REG_INIT    = 4'hC;
    localparam int unsigned CMD_RS_BIT  = 8;
    localparam int unsigned CMD_RW_BIT  = 9;
    localparam int unsigned INIT_GO_BIT = 0;
    localparam int unsigned INIT_N_BIT  = 1;
    localparam int unsigned INIT_M_BIT  = 2;
    localparam int unsigned INIT_G_BIT  = 3;
    localparam int unsigned INIT_STEPS  = 4;

    typedef enum logic [3:0] {
        INS_NOP, INS_CLR, INS_HOME, INS_ENTRY, INS_DCTL,
        INS_SHIFT, INS_FSET, INS_SETPAT, INS_SETTXT
    } lcdcg_ins_t;

    function automatic lcdcg_ins_t lcdcg_decode(input logic [7:0] d);
        lcdcg_ins_t r;
        r = INS_NOP;
        if (d[7])      r = INS_SETTXT;
        else if (d[6]) r = INS_SETPAT;
        else if (d[5]) r = INS_FSET;
        else if (d[4]) r = INS_SHIFT;
        else if (d[3]) r = INS_DCTL;
        else if (d[2]) r = INS_ENTRY;
        else if (d[1]) r = INS_HOME;
        else if (d[0]) r = INS_CLR;
        return r;
    endfunction : lcdcg_decode

    function automatic logic [6:0] lcdcg_step(input logic [6:0] a, input logic up);
        return up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    endfunction : lcdcg_step
endpackage : lcdcg_pkg
`default_nettype wire

// ---- verification/lcdcg_bench.sv ----
`default_nettype none
module lcdcg_bench
    import lcdcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BUSY = 300;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, q;
    logic        waitrequest;
    logic [7:0]  code = 8'h41;
    logic [2:0]  line = 3'h0;
    logic        cursor = 1'b0;
    logic [6:0]  scan = 7'h00;
    logic [4:0]  pixels;
    logic [7:0]  scan_char;
    logic [6:0]  ac, ofs;
    logic        user, busy, in_pat, disp, cur, blink, incr, shf, wid8, ln, lm, boost;
    int          err_total = 0;
    int          checked = 0;

    always #5 i_clk = ~i_clk;
    lcdcg_if link ();
    lcdcg_dev #(.BUSY_CYCLES(BUSY), .EXEC_CYCLES(EXEC_CYC)) u_lcdcg_dev (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .bus(link.dev),
        .i_pix_code(code), .i_pix_line(line), .i_pix_cursor(cursor), .i_rom_pixels(5'h0A),
        .i_scan_addr(scan), .o_pixels(pixels), .o_from_user_ram(user), .o_scan_char(scan_char),
        .o_busy_indicator(busy), .o_addr_counter(ac), .o_addr_in_pattern(in_pat),
        .o_disp_offset(ofs), .o_disp_on(disp), .o_cursor_on(cur), .o_blink_on(blink),
        .o_incr(incr), .o_shift_on_write(shf), .o_interface_width_select(wid8),
        .o_lines_n(ln), .o_lines_m(lm), .o_vgen_boost(boost));
    lcdcg_host u_lcdcg_host (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .bus(link.host),
        .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
        .i_avs_writedata(writedata), .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest));
    lcdcg_sva #(.BUSY_CYCLES(BUSY)) u_lcdcg_sva (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .req(link.req), .rs(link.rs), .rw(link.rw),
        .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid), .o_busy_indicator(busy),
        .o_addr_counter(ac), .o_addr_in_pattern(in_pat), .o_disp_on(disp), .o_incr(incr),
        .o_interface_width_select(wid8), .i_pix_code(code), .i_pix_cursor(cursor),
        .i_rom_pixels(5'h0A), .o_pixels(pixels), .o_from_user_ram(user));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Waitrequest and read data are taken at the rising edge that ends the transfer
    task automatic avs(input logic [3:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 5000);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 5000)
            cmp(32'(n), 32'h0);
    endtask : avs

    task automatic cmd(input logic [9:0] c);
        int n;
        n = 0;
        avs(REG_CMD, 1'b1, {22'h0, c});
        do begin
            avs(REG_STATUS, 1'b0, 32'h0);
            n++;
        end while ((q[0] !== 1'b0 || busy !== 1'b0) && n < 500);
        if (n >= 500)
            cmp(32'(n), 32'h0);
    endtask : cmd

    task automatic pix(input logic [7:0] c, input logic cu, input logic [5:0] exp);
        @(posedge i_clk);
        code <= c;
        line <= CURSOR_LINE;
        cursor <= cu;
        @(posedge i_clk);
        @(negedge i_clk);
        cmp({26'h0, user, pixels}, {26'h0, exp});
    endtask : pix

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_on();
        int n;
        n = 0;
        @(negedge i_clk);
        cmp({15'h0, ofs, wid8, incr, disp, cur, blink, shf, ln, lm, boost, in_pat},
            32'h300);
        while (busy === 1'b1 && n < 2 * BUSY) begin
            @(negedge i_clk);
            n++;
        end
        cmp(32'(n >= BUSY - 1 && n <= BUSY + 1), 32'h1);
        cmp({24'h0, scan_char}, {24'h0, BLANK_CODE});
    endtask : t_power_on

    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            cmd(10'(INS_FST_CODE | 8'h10 | 8'(i << 2)));
            cmp({30'h0, ln, lm}, 32'(i));
        end
    endtask : t_modes

    task automatic t_pattern();
        cmd(10'h0C5);
        cmd(10'h052);
        cmd(10'h200);
        cmp({24'h0, q[15:8]}, 32'h52);
        cmd(10'h0BF);
        cmd(10'h07F);
        cmd(10'h115);
        cmp({24'h0, in_pat, ac}, 32'hC0);
        // Bit 6 is now set and survives set-pattern; clear it first
        cmd(10'h0BF);
        cmd(10'h07F);
        cmd(10'h300);
        avs(REG_RDATA, 1'b0, 32'h0);
        cmp({24'h0, q[7:0]}, 32'h15);
    endtask : t_pattern

    task automatic t_pixels();
        cmd(10'h00E);
        pix(8'h07, 1'b0, 6'h35);
        pix(8'h07, 1'b1, 6'h3F);
        pix(8'h17, 1'b0, 6'h0A);
    endtask : t_pixels

    // Host sequence with N, M and G set; clear also homes the counter
    task automatic t_host_init();
        int n;
        n = 0;
        avs(REG_INIT, 1'b1, 32'h0F);
        do begin
            avs(REG_INIT, 1'b0, 32'h0);
            n++;
        end while ((q[0] !== 1'b0 || busy !== 1'b0) && n < 500);
        if (n >= 500)
            cmp(32'(n), 32'h0);
        cmp({18'h0, ln, lm, boost, disp, incr, wid8, in_pat, ac}, 32'h3B00);
    endtask : t_host_init

    task automatic t_unmapped();
        avs(4'h2, 1'b1, 32'hFFFFFFFF);
        avs(4'h2, 1'b0, 32'h0);
        cmp(q, 32'h0);
    endtask : t_unmapped

    initial begin
        #200us;
        err_total++;
        results();
    end

    initial begin
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_power_on();
        t_modes();
        t_pattern();
        t_pixels();
        t_host_init();
        t_unmapped();
        results();
    end
endmodule : lcdcg_bench
`default_nettype wire

// ---- verification/lcdcg_sva.sv ----
`default_nettype none
module lcdcg_sva
    import lcdcg_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = BUSY_CYC
) (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       req,
    input wire logic       rs,
    input wire logic       rw,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rvalid,
    input wire logic       o_busy_indicator,
    input wire logic [6:0] o_addr_counter,
    input wire logic       o_addr_in_pattern,
    input wire logic       o_disp_on,
    input wire logic       o_incr,
    input wire logic       o_interface_width_select,
    input wire logic [7:0] i_pix_code,
    input wire logic       i_pix_cursor,
    input wire logic [4:0] i_rom_pixels,
    input wire logic [4:0] o_pixels,
    input wire logic       o_from_user_ram
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt_r;
    // Saturates so a long run cannot wrap back into the busy span
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            cnt_r <= 0;
        else if (cnt_r < BUSY_CYCLES)
            cnt_r <= cnt_r + 1;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_poll;
        req && !rs && rw;
    endsequence
    sequence s_instr;
        req && !rs && !rw && !o_busy_indicator;
    endsequence
    a_read_answer: assert property (req && rw |=> rvalid)
        else $error("read not answered");
    a_poll_format: assert property (s_poll |=> rdata[6:0] == $past(o_addr_counter)
        && rdata[7] == $past(o_busy_indicator)) else $error("busy read byte wrong");
    a_busy_ignored: assert property (req && o_busy_indicator && (rs || !rw)
        |=> $stable(o_addr_counter) && $stable(o_disp_on)) else $error("busy access ran");
    a_host_waits: assert property (req && (rs || !rw) |-> !o_busy_indicator)
        else $error("host sent while busy");
    a_init_busy: assert property (cnt_r + 1 < BUSY_CYCLES |-> o_busy_indicator)
        else $error("busy ended early");
    a_reset_state: assert property ($fell(i_sys_rst) |-> o_interface_width_select
        && o_incr && !o_disp_on && !o_addr_in_pattern) else $error("bad reset state");
    a_setpat_low: assert property (s_instr ##0 wdata[7:6] == 2'h1 |=> o_addr_in_pattern
        && o_addr_counter == {$past(o_addr_counter[6]), $past(wdata[5:0])})
        else $error("pattern address load wrong");
    a_settxt_full: assert property (s_instr ##0 wdata[7] |=> !o_addr_in_pattern
        && o_addr_counter == $past(wdata[6:0])) else $error("text address load wrong");
    a_user_select: assert property (!$past(i_sys_rst) |->
        o_from_user_ram == ($past(i_pix_code[7:4]) == 4'h0)) else $error("glyph source wrong");
    a_rom_pixels: assert property (o_disp_on && i_pix_code[7:4] != 4'h0 && !i_pix_cursor
        |=> o_pixels == $past(i_rom_pixels)) else $error("rom row wrong");
endmodule : lcdcg_sva
`default_nettype wire
